// file: rtl/sbe_pkg.sv
// package: constants, types and states of the secure bus encryptor
package sbe_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int KEY_W = 64;
  localparam int VEC_BYTES = 48;
  localparam int VEC_IDX_W = 6;
  localparam int WIPE_WORDS = 32768;
  localparam int RD_LAT = 2;
  localparam logic [16:0] LFSR_SEED = 17'h1ACE5;
  localparam logic [16:0] LFSR_TAPS = 17'h12000;
  localparam logic [1:0] RANGE_32K = 2'h0;
  localparam logic [1:0] RANGE_64K = 2'h1;
  localparam logic [31:0] MIX_MUL = 32'h9E3779B1;
  // gray order along the usual path: wipe, open, ready, sealed
  typedef enum logic [1:0] {
    LK_WIPE = 2'b01,
    LK_OPEN = 2'b00,
    LK_READY = 2'b10,
    LK_SEALED = 2'b11
  } sbe_lock_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [16:0] addr;
    logic [7:0] data;
  } sbe_req_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic data_oe;
    logic [16:0] addr;
    logic [7:0] data;
  } sbe_mem_t;
  localparam sbe_mem_t MEM_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
    data_oe: 1'b0, addr: 17'h00000, data: 8'h00};
endpackage

// file: rtl/sbe_cipher.sv
// combinational address permutation and byte transform
`timescale 1ns/1ns
`default_nettype none
module sbe_cipher (
  input wire logic [63:0] key_i,
  input wire logic [1:0] range_i,
  input wire logic [16:0] enc_addr_i,
  input wire logic [7:0] enc_data_i,
  input wire logic [16:0] dec_addr_i,
  input wire logic [7:0] dec_data_i,
  output logic [16:0] phys_addr_o,
  output logic [7:0] enc_data_o,
  output logic [7:0] dec_data_o
);
  import sbe_pkg::*;

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [16:0] range_mask(input logic [1:0] r);
    if (r == RANGE_32K) begin
      return 17'h07FFF;
    end else if (r == RANGE_64K) begin
      return 17'h0FFFF;
    end
    return 17'h1FFFF;
  endfunction

  // every step is invertible modulo the range, so the whole is a bijection
  function automatic logic [16:0] permute(input logic [16:0] a,
      input logic [63:0] k, input logic [16:0] m);
    logic [16:0] x;
    x = a & m;
    x = 17'(x + k[16:0]) & m;
    x = x ^ ((x << 3) & m);
    x = 17'(x * {k[32:17], 1'b1}) & m;
    x = x ^ (x >> 5);
    x = (x ^ k[49:33]) & m;
    return x;
  endfunction

  // xor pad, add pad and rotation, all from key and logical address
  function automatic logic [18:0] pad(input logic [63:0] k,
      input logic [16:0] a);
    logic [31:0] t;
    t = k[63:32] ^ k[31:0] ^ {15'h0000, a};
    t = 32'(t * MIX_MUL);
    t = t ^ (t >> 15);
    return t[18:0];
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] d,
      input logic [2:0] r);
    logic [15:0] t;
    t = {d, d} << r;
    return t[15:8];
  endfunction

  function automatic logic [7:0] rotr(input logic [7:0] d,
      input logic [2:0] r);
    logic [15:0] t;
    t = {d, d} >> r;
    return t[7:0];
  endfunction

  // ************************************************
  // datapath
  // ************************************************
  wire logic [18:0] enc_pad = pad(key_i, enc_addr_i);
  wire logic [18:0] dec_pad = pad(key_i, dec_addr_i);
  assign phys_addr_o = permute(enc_addr_i, key_i, range_mask(range_i));
  assign enc_data_o = rotl(8'((enc_data_i ^ enc_pad[7:0]) + enc_pad[15:8]),
    enc_pad[18:16]);
  assign dec_data_o = 8'(rotr(dec_data_i, dec_pad[18:16]) - dec_pad[15:8])
    ^ dec_pad[7:0];
endmodule
`default_nettype wire

// file: rtl/sbe_top.sv
// secure bus encryptor: lock, key, vector store and encrypted bus cycles
`timescale 1ns/1ns
`default_nettype none
module sbe_top #(
  parameter int WIPE_WORDS = sbe_pkg::WIPE_WORDS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic battery_por_i,
  input wire logic tamper_destruct_input_i,
  input wire logic boot_mode_i,
  input wire logic lock_clear_i,
  input wire logic lock_set_i,
  input wire logic key_load_i,
  input wire logic [63:0] trng_word_i,
  input wire logic [1:0] range_cfg_i,
  input wire sbe_pkg::sbe_req_t cpu_req_i,
  input wire logic [7:0] mem_data_i,
  input wire logic vec_we_i,
  input wire logic [5:0] vec_idx_i,
  input wire logic [7:0] vec_wdata_i,
  output var sbe_pkg::sbe_mem_t mem_o,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_rvalid_o,
  output logic load_refused_o,
  output logic [7:0] vec_rdata_o,
  output logic lock_o,
  output logic wipe_busy_o
);
  import sbe_pkg::*;

  // ************************************************
  // nonvolatile state: lock, key, range, vectors
  // ************************************************
  // battery_por_i stands for battery attach; reset_i leaves these alone
  sbe_lock_t lk_q;
  logic [63:0] key_q;
  logic [1:0] range_q;
  logic [16:0] wipe_cnt_q;
  logic [7:0] vec_q [VEC_BYTES];

  wire logic erase = tamper_destruct_input_i
    | (boot_mode_i & lock_clear_i);
  wire logic wiping = (lk_q == LK_WIPE);
  wire logic load_ok = (lk_q == LK_READY);
  wire logic wipe_last = (wipe_cnt_q == 17'(WIPE_WORDS - 1));
  wire logic key_take = boot_mode_i & key_load_i
    & (lk_q == LK_OPEN || lk_q == LK_READY);
  wire logic vec_hit = ({26'h0, vec_idx_i} < VEC_BYTES);

  always_ff @(posedge clk_sys_i) begin
    if (battery_por_i || erase) begin
      lk_q <= LK_WIPE;
      key_q <= 64'h0000000000000000;
      wipe_cnt_q <= 17'h00000;
    end else begin
      case (lk_q)
        LK_WIPE: begin
          wipe_cnt_q <= 17'(wipe_cnt_q + 17'h00001);
          if (wipe_last) begin
            lk_q <= LK_OPEN;
          end
        end
        LK_OPEN: begin
          if (key_take) begin
            key_q <= trng_word_i;
            lk_q <= LK_READY;
          end
        end
        LK_READY: begin
          if (key_take) begin
            key_q <= trng_word_i;
          end else if (boot_mode_i && lock_set_i) begin
            lk_q <= LK_SEALED;
          end
        end
        default: begin
          lk_q <= LK_SEALED;
        end
      endcase
    end
  end

  // range is only reconfigured in boot mode while lock_o is low and no wipe runs
  always_ff @(posedge clk_sys_i) begin
    if (battery_por_i) begin
      range_q <= RANGE_32K;
    end else if (boot_mode_i && !lock_o && !wiping) begin
      range_q <= range_cfg_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (battery_por_i || erase) begin
      for (int i = 0; i < VEC_BYTES; i++) begin
        vec_q[i] <= 8'h00;
      end
    end else if (vec_we_i && boot_mode_i && load_ok && vec_hit) begin
      vec_q[vec_idx_i] <= vec_wdata_i;
    end
  end

  // ************************************************
  // bus cycle selection
  // ************************************************
  logic [16:0] lfsr_q;
  logic pend_q;
  logic [16:0] pend_addr_q;
  logic [16:0] phys_addr;
  logic [7:0] enc_data;
  logic [7:0] dec_data;

  wire logic exec = !boot_mode_i;
  wire logic real_ok = cpu_req_i.valid & !wiping & (exec | load_ok);
  // requests during the wipe are ignored without an indication
  wire logic refuse = cpu_req_i.valid & boot_mode_i & !load_ok
    & !wiping;
  wire logic dummy = exec & !wiping & !cpu_req_i.valid;
  wire logic [16:0] enc_addr = cpu_req_i.valid ? cpu_req_i.addr : lfsr_q;
  wire logic [16:0] lfsr_nxt = lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS)
    : (lfsr_q >> 1);

  // single shared cipher, no bypass path exists except the raw wipe cycles
  sbe_cipher u_cipher (
    .key_i(key_q),
    .range_i(range_q),
    .enc_addr_i(enc_addr),
    .enc_data_i(cpu_req_i.data),
    .dec_addr_i(pend_addr_q),
    .dec_data_i(mem_data_i),
    .phys_addr_o(phys_addr),
    .enc_data_o(enc_data),
    .dec_data_o(dec_data)
  );

  sbe_mem_t mem_d;
  always_comb begin
    mem_d = MEM_IDLE;
    if (wiping) begin
      // physical wipe: key is gone, so plain zeros at raw addresses
      mem_d.ce_n = 1'b0;
      mem_d.we_n = 1'b0;
      mem_d.data_oe = 1'b1;
      mem_d.addr = wipe_cnt_q;
    end else if (real_ok || dummy) begin
      mem_d.ce_n = 1'b0;
      mem_d.addr = phys_addr;
      if (real_ok && cpu_req_i.write) begin
        mem_d.we_n = 1'b0;
        mem_d.data_oe = 1'b1;
        mem_d.data = enc_data;
      end else begin
        mem_d.oe_n = 1'b0;
      end
    end
  end

  // ************************************************
  // registers of the bus side
  // ************************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mem_o <= MEM_IDLE;
      lfsr_q <= LFSR_SEED;
      pend_q <= 1'b0;
      pend_addr_q <= 17'h00000;
      cpu_rdata_o <= 8'h00;
      cpu_rvalid_o <= 1'b0;
      load_refused_o <= 1'b0;
    end else begin
      mem_o <= mem_d;
      if (dummy) begin
        lfsr_q <= lfsr_nxt;
      end
      pend_q <= real_ok & !cpu_req_i.write;
      pend_addr_q <= cpu_req_i.addr;
      cpu_rvalid_o <= pend_q;
      if (pend_q) begin
        cpu_rdata_o <= dec_data;
      end
      load_refused_o <= refuse;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vec_rdata_o <= 8'h00;
      lock_o <= 1'b0;
      wipe_busy_o <= 1'b0;
    end else begin
      vec_rdata_o <= vec_hit ? vec_q[vec_idx_i] : 8'h00;
      lock_o <= (lk_q == LK_SEALED);
      wipe_busy_o <= wiping;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  logic vec_zero;
  always_comb begin
    vec_zero = 1'b1;
    for (int i = 0; i < VEC_BYTES; i++) begin
      vec_zero = vec_zero & (vec_q[i] == 8'h00);
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  chk_read_latency: assert property (
    real_ok && !cpu_req_i.write |-> ##2 cpu_rvalid_o)
    else $error("real read not answered after two cycles");
  chk_dummy_dropped: assert property (
    dummy |-> ##2 (!cpu_rvalid_o && $stable(cpu_rdata_o)))
    else $error("dummy read reached the core");
  chk_clear_erases: assert property (
    boot_mode_i && lock_clear_i |=> key_q == 64'h0 && lk_q == LK_WIPE)
    else $error("lock clear left key or state");
  chk_tamper_erases: assert property (
    tamper_destruct_input_i |=> key_q == 64'h0 && vec_zero)
    else $error("tamper left key or vectors");
  chk_load_refused: assert property (
    refuse |=> load_refused_o && mem_o.we_n)
    else $error("load accepted with lock not cleared");
  chk_write_enc: assert property (
    real_ok && cpu_req_i.write |=> !mem_o.we_n && mem_o.data_oe
      && mem_o.data == $past(enc_data) && mem_o.addr == $past(phys_addr))
    else $error("write not driven encrypted");
  chk_idle_dummy: assert property (
    dummy |=> !mem_o.ce_n && !mem_o.oe_n && mem_o.we_n)
    else $error("idle cycle without dummy read");
  chk_key_source: assert property (
    !$stable(key_q) |-> $past(key_take) && key_q == $past(trng_word_i)
      || key_q == 64'h0)
    else $error("key changed without random load");
  chk_wipe_zero: assert property (
    wiping && !erase |=> !mem_o.we_n && mem_o.data == 8'h00
      && mem_o.addr == $past(wipe_cnt_q))
    else $error("wipe cycle not writing zero");
  chk_range_held: assert property (
    mem_o.addr[16] == 1'b0 || $past(range_q[1]) || $past(wiping))
    else $error("address outside configured range");

  cov_dummy_then_real: cover property (dummy ##1 real_ok);
  cov_seal: cover property (lk_q == LK_READY ##1 lk_q == LK_SEALED);
  cov_tamper_sealed: cover property (lock_o && tamper_destruct_input_i);
endmodule
`default_nettype wire

// file: dv/sbe_sram_model.sv
// byte-wide static ram model on the far side of the encrypted bus
`timescale 1ns/1ns
`default_nettype none
module sbe_sram_model (
  input wire logic clk_sys_i,
  input wire sbe_pkg::sbe_mem_t mem_i,
  output logic [7:0] mem_data_o
);
  import sbe_pkg::*;
  // ****************************************
  // storage and bus answer
  // ****************************************
  logic [7:0] mem [0:131071];
  logic [7:0] last_q;
  logic rd_en;
  initial begin
    for (int i = 0; i < 131072; i++) begin
      mem[i] = 8'hA5;
    end
    last_q = 8'h00;
  end
  assign rd_en = !mem_i.ce_n && !mem_i.oe_n;
  // released lines show the inverse, so a stale byte never passes
  assign mem_data_o = rd_en ? mem[mem_i.addr] : ~last_q;
  always @(posedge clk_sys_i) begin
    if (!mem_i.ce_n && !mem_i.we_n && mem_i.data_oe) begin
      mem[mem_i.addr] <= mem_i.data;
    end
    if (rd_en) begin
      last_q <= mem[mem_i.addr];
    end
  end
endmodule
`default_nettype wire

// file: dv/sbe_top_tb_top.sv
// testbench of the secure bus encryptor against the sram model
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %0t %s", $time, msg); \
    end \
  end
module sbe_top_tb_top;
  import sbe_pkg::*;
  // short wipe keeps the run brief
  localparam int WW = 8;
  logic clk_sys_i, reset_i, por, tamper, boot, clr, set, kld, vwe;
  logic [63:0] trng;
  logic [7:0] mdat, vwd, rdata, vrd, base;
  logic [7:0] dat [16];
  sbe_req_t req;
  sbe_mem_t mem;
  logic rvalid, refused, lock, wbusy;
  logic [7:0] expq [$];
  int err_total, compares, seed;
  sbe_top #(.WIPE_WORDS(WW)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .battery_por_i(por), .tamper_destruct_input_i(tamper),
    .boot_mode_i(boot), .lock_clear_i(clr), .lock_set_i(set),
    .key_load_i(kld), .trng_word_i(trng), .range_cfg_i(2'h2),
    .cpu_req_i(req), .mem_data_i(mdat), .vec_we_i(vwe),
    .vec_idx_i(6'h2F), .vec_wdata_i(vwd), .mem_o(mem),
    .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid),
    .load_refused_o(refused), .vec_rdata_o(vrd), .lock_o(lock),
    .wipe_busy_o(wbusy));
  sbe_sram_model sram (.clk_sys_i(clk_sys_i), .mem_i(mem),
    .mem_data_o(mdat));
  // ****************************************
  // clock, tasks, read watcher
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [16:0] a,
    input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{1'b1, w, a, d};
    if (!w) begin
      expq.push_back(d);
    end
  endtask
  task automatic idle();
    @(posedge clk_sys_i);
    req <= '{1'b0, 1'b0, 17'h00000, 8'h00};
  endtask
  task automatic ctl(input logic [3:0] v);
    @(posedge clk_sys_i);
    {tamper, clr, set, kld} <= v;
    trng <= {$random(seed), $random(seed)};
    @(posedge clk_sys_i);
    {tamper, clr, set, kld} <= 4'h0;
  endtask
  task automatic vec_wr();
    @(posedge clk_sys_i);
    vwe <= 1'b1;
    vwd <= 8'($random(seed));
    @(posedge clk_sys_i);
    vwe <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(vrd, vwd, "vector readback")
  endtask
  task automatic wipe_wait();
    int n;
    n = 0;
    repeat (2) @(posedge clk_sys_i);
    while (wbusy !== 1'b0 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    repeat (2) @(posedge clk_sys_i);
    `CHK(wbusy, 1'b0, "wipe ended")
  endtask
  // dummy reads never raise rvalid, so an extra one finds no note
  always @(posedge clk_sys_i) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        `CHK(1'b1, 1'b0, "read with no request")
      end else begin
        `CHK(rdata, expq.pop_front(), "read data")
      end
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 32'hE6F05FA3;
    err_total = 0;
    compares = 0;
    {reset_i, por, tamper, boot, clr, set, kld, vwe} = 8'h90;
    trng = 64'h0;
    vwd = 8'h00;
    req = '0;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    por <= 1'b1;
    @(posedge clk_sys_i);
    por <= 1'b0;
    wipe_wait();
    for (int i = 0; i < WW; i++) begin
      `CHK(sram.mem[i], 8'h00, "wipe zero")
    end
    $display("test wipe done");
    bus(1'b1, 17'h00005, 8'h00);
    idle();
    #1;
    `CHK(refused, 1'b1, "boot access not refused")
    `CHK(mem.ce_n, 1'b1, "refused access on bus")
    $display("test refusal done");
    ctl(4'h1);
    vec_wr();
    base = 8'($random(seed));
    for (int i = 0; i < 16; i++) begin
      dat[i] = base + 8'(i);
      bus(1'b1, 17'(i * 8191), dat[i]);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 17'(i * 8191), dat[i]);
    end
    idle();
    #1;
    `CHK({mem.ce_n, mem.oe_n}, 2'b00, "read strobes")
    @(posedge clk_sys_i);
    #1;
    `CHK(rvalid, 1'b1, "read latency")
    $display("test boot load done");
    @(posedge clk_sys_i);
    boot <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bus(1'b0, 17'(i * 8191), dat[i]);
      idle();
      #1;
      `CHK({mem.ce_n, mem.oe_n, mem.we_n}, 3'b001, "real read")
      @(posedge clk_sys_i);
      #1;
      `CHK({mem.ce_n, mem.oe_n, mem.we_n}, 3'b001, "dummy read")
    end
    $display("test execution done");
    @(posedge clk_sys_i);
    boot <= 1'b1;
    ctl(4'h2);
    @(posedge clk_sys_i);
    #1;
    `CHK(lock, 1'b1, "lock set")
    ctl(4'h4);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(vrd, 8'h00, "vectors kept after clear")
    `CHK(lock, 1'b0, "lock kept after clear")
    wipe_wait();
    $display("test lock clear done");
    ctl(4'h1);
    vec_wr();
    @(posedge clk_sys_i);
    boot <= 1'b0;
    ctl(4'h8);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(vrd, 8'h00, "vectors kept after tamper")
    `CHK(wbusy, 1'b1, "no wipe after tamper")
    wipe_wait();
    $display("test tamper done");
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
